// [common/cat_pkg.sv]
// Constants and types for the counter array timebase and its channels.
// Assumes a single system clock; all register effects are plain ports.
//
// Contract
// - Sixteen-bit up-counter read as a low byte and a high byte.
// - Low byte read latches high byte; next high read returns it.
// - Reads never disturb counting.
// - Three-bit select picks one of seven count sources; 111 reserved.
// - Wrap from FFFF to 0000 sets the wrap flag.
// - Wrap flag raises interrupt request only when its enable is set.
// - Hardware never clears the wrap flag; software clears it.
// - With idle halt select clear, counting continues in CPU idle.
// - Up to three channels, each a 16-bit capture/compare module.
// - Channel modes: capture, software timer, fast output, frequency, PWM.
// - Channel pin reaches the port only when its routing is enabled.
// - PWM at 8, 9, 10, 11 or 16 bits, centre or edge aligned.
// - Capture on rising, falling or either edge of channel input.
package cat_pkg;

  localparam int CAT_CNT_W  = 16;
  localparam int CAT_BYTE_W = 8;
  localparam int CAT_SEL_W  = 3;

  // Timebase select codes
  localparam logic [2:0] CAT_TB_DIV12 = 3'h0;
  localparam logic [2:0] CAT_TB_DIV4  = 3'h1;
  localparam logic [2:0] CAT_TB_T0OVF = 3'h2;
  localparam logic [2:0] CAT_TB_EXTIN = 3'h3;
  localparam logic [2:0] CAT_TB_SYS   = 3'h4;
  localparam logic [2:0] CAT_TB_XOSC  = 3'h5;
  localparam logic [2:0] CAT_TB_LFOSC = 3'h6;
  localparam logic [2:0] CAT_TB_RSVD  = 3'h7;

  // Divider counts
  localparam logic [3:0] CAT_DIV12_LAST = 4'hB;
  localparam logic [1:0] CAT_DIV4_LAST  = 2'h3;
  localparam logic [2:0] CAT_OSC_LAST   = 3'h7;

  // Reset, wrap and PWM mask values
  localparam logic [15:0] CAT_CNT_RST = 16'h0000;
  localparam logic [15:0] CAT_CNT_MAX = 16'hFFFF;
  localparam logic [7:0]  CAT_BYTE_RST = 8'h00;
  localparam logic [15:0] CAT_PWM8_MASK = 16'h00FF;

  // Channel operating modes
  typedef enum logic [2:0] {
    CAT_MODE_CAPTURE = 3'h0,
    CAT_MODE_SWTIMER = 3'h1,
    CAT_MODE_FREQ    = 3'h2,
    CAT_MODE_HSO     = 3'h3,
    CAT_MODE_PWM     = 3'h6
  } cat_mode_type;

endpackage : cat_pkg

// [rtl/cat_sync.sv]
// Three-stage synchronizer with agreement filter for pin-level inputs.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module cat_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk, // System clock
  input  wire logic             sys_rst,  // Synchronous reset, high
  input  wire logic [WIDTH-1:0] async_in, // Raw pin levels
  output logic      [WIDTH-1:0] sync_out  // Filtered synchronous levels
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : cat_sync
`default_nettype wire

// [rtl/cat_timebase.sv]
// Shared 16-bit counter, timebase selection and capture/compare channels.
// Assumes read and clear strobes are one-cycle pulses on core_clk.
`timescale 1ns/1ns
`default_nettype none
module cat_timebase
  import cat_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input  wire logic                core_clk,             // 25 MHz clock
  input  wire logic                sys_rst,              // Sync reset, high
  input  wire logic [2:0]          timebase_select,      // Count source
  input  wire logic                timer0_ovf,           // Timer 0 overflow
  input  wire logic                external_count_input, // Count pin
  input  wire logic                ext_osc,              // External osc
  input  wire logic                lf_osc,               // Low-freq osc
  input  wire logic                cpu_idle,             // CPU in idle
  input  wire logic                idle_halt_select,     // Halt in idle
  input  wire logic                rd_low_stb,           // Read low byte
  input  wire logic                rd_high_stb,          // Read high byte
  output logic [7:0]               rd_data,              // Read answer
  output logic [7:0]               count_low_byte,       // Live low byte
  output logic [7:0]               count_high_byte,      // Live high byte
  output logic                     wrap_flag,            // Wrap flag
  input  wire logic                wrap_flag_clr,        // Clear wrap flag
  input  wire logic                wrap_irq_enable,      // Wrap irq enable
  output logic                     irq,                  // Interrupt request
  input  wire logic [3*NUM_CH-1:0] ch_mode,              // Mode per channel
  input  wire logic [NUM_CH-1:0]   ch_cap_pos,           // Capture rising
  input  wire logic [NUM_CH-1:0]   ch_cap_neg,           // Capture falling
  input  wire logic [NUM_CH-1:0]   ch_cmp_en,            // Comparator on
  input  wire logic [NUM_CH-1:0]   ch_pwm16,             // 16-bit PWM
  input  wire logic [NUM_CH-1:0]   ch_center,            // Centre aligned
  input  wire logic [1:0]          pwm_len_sel,          // 8..11 bit PWM
  input  wire logic [NUM_CH-1:0]   ch_cmp_wr,            // Compare write
  input  wire logic [16*NUM_CH-1:0] ch_cmp_wdata,        // Compare data
  output logic [16*NUM_CH-1:0]     ch_cmp_val,           // Compare/capture
  output logic [NUM_CH-1:0]        ch_flag,              // Channel flag
  input  wire logic [NUM_CH-1:0]   ch_flag_clr,          // Clear flag
  input  wire logic [NUM_CH-1:0]   ch_route_en,          // Crossbar route
  input  wire logic [NUM_CH-1:0]   channel_pin_in,       // Pin level in
  output logic [NUM_CH-1:0]        channel_pin_out,      // Pin drive
  output logic [NUM_CH-1:0]        channel_pin_oe        // Pin enable
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] pwm_mask(input logic p16,
                                           input logic [1:0] len);
    logic [15:0] m;
    m = CAT_PWM8_MASK;
    if (p16) begin
      m = CAT_CNT_MAX;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (k < int'(len)) begin
          m = {m[14:0], 1'b1};
        end
      end
    end
    return m;
  endfunction : pwm_mask

  // ---------------------------------------------------------------
  // Synchronizers
  // ---------------------------------------------------------------
  logic [NUM_CH+2:0] sync_lv;
  logic [NUM_CH+2:0] sync_prev_q;
  cat_sync #(.WIDTH(NUM_CH + 3)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({channel_pin_in, lf_osc, ext_osc, external_count_input}),
    .sync_out (sync_lv)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_prev_q <= '0;
    end else begin
      sync_prev_q <= sync_lv;
    end
  end

  logic ext_fall;
  logic xosc_rise;
  logic lfo_rise;
  assign ext_fall  = sync_prev_q[0] & ~sync_lv[0];
  assign xosc_rise = sync_lv[1] & ~sync_prev_q[1];
  assign lfo_rise  = sync_lv[2] & ~sync_prev_q[2];

  // ---------------------------------------------------------------
  // Prescalers
  // ---------------------------------------------------------------
  logic [3:0] div12_q;
  logic [1:0] div4_q;
  logic [2:0] xdiv_q;
  logic [2:0] ldiv_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div12_q <= '0;
      div4_q  <= '0;
    end else begin
      div12_q <= (div12_q == CAT_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
      div4_q  <= div4_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      xdiv_q <= '0;
      ldiv_q <= '0;
    end else begin
      if (xosc_rise) begin
        xdiv_q <= xdiv_q + 3'h1;
      end
      if (lfo_rise) begin
        ldiv_q <= ldiv_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timebase and counter
  // ---------------------------------------------------------------
  logic src_tick;
  logic halted;
  logic tick;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [7:0]  snap_q;

  always_comb begin
    case (timebase_select)
      CAT_TB_DIV12: src_tick = (div12_q == CAT_DIV12_LAST);
      CAT_TB_DIV4:  src_tick = (div4_q == CAT_DIV4_LAST);
      CAT_TB_T0OVF: src_tick = timer0_ovf;
      CAT_TB_EXTIN: src_tick = ext_fall;
      CAT_TB_SYS:   src_tick = 1'b1;
      CAT_TB_XOSC:  src_tick = xosc_rise && (xdiv_q == CAT_OSC_LAST);
      CAT_TB_LFOSC: src_tick = lfo_rise && (ldiv_q == CAT_OSC_LAST);
      default:      src_tick = 1'b0;
    endcase
  end

  assign halted = cpu_idle & idle_halt_select;
  assign tick   = src_tick & ~halted;
  assign cnt_d  = tick ? cnt_q + 16'h0001 : cnt_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= CAT_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count_low_byte  = cnt_q[7:0];
  assign count_high_byte = cnt_q[15:8];

  // Low read latches the high byte; high read returns the latch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      snap_q  <= CAT_BYTE_RST;
      rd_data <= CAT_BYTE_RST;
    end else if (rd_low_stb) begin
      snap_q  <= cnt_q[15:8];
      rd_data <= cnt_q[7:0];
    end else if (rd_high_stb) begin
      rd_data <= snap_q;
    end
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrap_flag <= 1'b0;
    end else if (tick && cnt_q == CAT_CNT_MAX) begin
      wrap_flag <= 1'b1;
    end else if (wrap_flag_clr) begin
      wrap_flag <= 1'b0;
    end
  end

  assign irq = wrap_flag & wrap_irq_enable;

  a_wrap_sets_flag : assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && cnt_q == CAT_CNT_MAX |=> wrap_flag && cnt_q == CAT_CNT_RST)
    else $error("wrap did not set flag");
  a_irq_gate : assert property (@(posedge core_clk) disable iff (sys_rst)
    irq == (wrap_flag && wrap_irq_enable))
    else $error("irq not gated by enable");
  a_flag_sticky : assert property (@(posedge core_clk) disable iff (sys_rst)
    wrap_flag && !wrap_flag_clr |=> wrap_flag)
    else $error("wrap flag cleared by hardware");
  a_snap_read : assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_low_stb ##1 (!rd_low_stb && !rd_high_stb) [*2] ##1 rd_high_stb
    |=> rd_data == $past(cnt_q[15:8], 4))
    else $error("high read did not return snapshot");
  a_read_count : assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_low_stb || rd_high_stb) |=> cnt_q == $past(cnt_d))
    else $error("read disturbed counter");
  a_sys_step : assert property (@(posedge core_clk) disable iff (sys_rst)
    timebase_select == CAT_TB_SYS && !halted
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("system clock source did not step by one");
  a_idle_runs : assert property (@(posedge core_clk) disable iff (sys_rst)
    cpu_idle && !idle_halt_select && src_tick |=> cnt_q != $past(cnt_q))
    else $error("counter stalled in idle");
  a_rsvd_still : assert property (@(posedge core_clk) disable iff (sys_rst)
    timebase_select == CAT_TB_RSVD [*2] |-> $stable(cnt_q))
    else $error("reserved source advanced counter");

  // ---------------------------------------------------------------
  // Capture/compare channels
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    cat_mode_type mode;
    logic [15:0]  cmp_q;
    logic [15:0]  mask;
    logic [15:0]  pos;
    logic [15:0]  fold;
    logic         pin_rise;
    logic         pin_fall;
    logic         cap_ev;
    logic         match;
    logic         fmatch;
    logic         pwm_lv;
    logic         pin_q;
    logic         flag_q;

    assign mode     = cat_mode_type'(ch_mode[3*c +: 3]);
    assign pin_rise = sync_lv[3+c] & ~sync_prev_q[3+c];
    assign pin_fall = sync_prev_q[3+c] & ~sync_lv[3+c];
    assign cap_ev   = (mode == CAT_MODE_CAPTURE)
                      && ((ch_cap_pos[c] && pin_rise)
                      || (ch_cap_neg[c] && pin_fall));
    assign match    = tick && ch_cmp_en[c] && (cnt_d == cmp_q);
    assign fmatch   = tick && ch_cmp_en[c] && (cnt_d[7:0] == cmp_q[7:0]);
    assign mask     = pwm_mask(ch_pwm16[c], pwm_len_sel);
    assign pos      = cnt_q & mask;
    assign fold     = |(pos & (mask ^ (mask >> 1))) ? (~pos & mask) : pos;
    assign pwm_lv   = ch_cmp_en[c] && (ch_center[c]
                      ? ({fold[14:0], 1'b0} < (cmp_q & mask))
                      : (pos < (cmp_q & mask)));

    // Capture, compare register and frequency reload
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        cmp_q <= CAT_CNT_RST;
      end else if (ch_cmp_wr[c]) begin
        cmp_q <= ch_cmp_wdata[16*c +: 16];
      end else if (cap_ev) begin
        cmp_q <= cnt_q;
      end else if (mode == CAT_MODE_FREQ && fmatch) begin
        cmp_q[7:0] <= cmp_q[7:0] + cmp_q[15:8];
      end
    end

    // Channel output level per mode
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        pin_q <= 1'b0;
      end else begin
        case (mode)
          CAT_MODE_HSO:  pin_q <= pin_q ^ match;
          CAT_MODE_FREQ: pin_q <= pin_q ^ fmatch;
          CAT_MODE_PWM:  pin_q <= pwm_lv;
          default:       pin_q <= 1'b0;
        endcase
      end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        flag_q <= 1'b0;
      end else if (cap_ev || (match && (mode == CAT_MODE_SWTIMER
                                        || mode == CAT_MODE_HSO))) begin
        flag_q <= 1'b1;
      end else if (ch_flag_clr[c]) begin
        flag_q <= 1'b0;
      end
    end

    assign ch_cmp_val[16*c +: 16] = cmp_q;
    assign ch_flag[c]             = flag_q;
    assign channel_pin_out[c]     = pin_q;
    assign channel_pin_oe[c]      = ch_route_en[c]
                                    && (mode == CAT_MODE_HSO
                                    || mode == CAT_MODE_FREQ
                                    || mode == CAT_MODE_PWM);

    a_capture_edge : assert property (@(posedge core_clk) disable iff (sys_rst)
      cap_ev && !ch_cmp_wr[c] |=> cmp_q == $past(cnt_q) && flag_q)
      else $error("capture did not load count");
    a_route_gate : assert property (@(posedge core_clk) disable iff (sys_rst)
      !ch_route_en[c] |-> !channel_pin_oe[c])
      else $error("unrouted pin driven");
    a_hso_toggle : assert property (@(posedge core_clk) disable iff (sys_rst)
      mode == CAT_MODE_HSO && match ##1 mode == CAT_MODE_HSO
      |-> pin_q != $past(pin_q))
      else $error("fast output did not toggle on match");
  end

endmodule : cat_timebase
`default_nettype wire

// [tb/cat_timebase_tb.sv]
// Self-checking bench for the shared counter, timebase and capture logic.
// Assumes cat_pkg and rtl/cat_timebase.sv are compiled first.
`timescale 1ns/1ns
`default_nettype none
module cat_timebase_tb
  import cat_pkg::*;
;
  logic        core_clk, sys_rst, timer0_ovf, external_count_input;
  logic        ext_osc, lf_osc, cpu_idle, idle_halt_select;
  logic        rd_low_stb, rd_high_stb, wrap_flag_clr, wrap_irq_enable;
  logic        wrap_flag, irq;
  logic [2:0]  timebase_select, ch_cap_pos, ch_cap_neg, ch_cmp_wr;
  logic [2:0]  ch_flag_clr, channel_pin_in, ch_flag;
  logic [2:0]  channel_pin_out, channel_pin_oe;
  logic [2:0]  ch_cmp_en, ch_route_en;
  logic [7:0]  rd_data, count_low_byte, count_high_byte;
  logic [8:0]  ch_mode;
  logic [47:0] ch_cmp_wdata, ch_cmp_val;
  logic [15:0] exp_q;
  int          n_fail, n_compared;
  int          cyc = 0;

  cat_timebase #(.NUM_CH(3)) dut (
    .core_clk, .sys_rst, .timebase_select, .timer0_ovf,
    .external_count_input, .ext_osc, .lf_osc, .cpu_idle,
    .idle_halt_select, .rd_low_stb, .rd_high_stb, .rd_data,
    .count_low_byte, .count_high_byte, .wrap_flag, .wrap_flag_clr,
    .wrap_irq_enable, .irq, .ch_mode, .ch_cap_pos, .ch_cap_neg,
    .ch_cmp_en, .ch_pwm16(3'h0), .ch_center(3'h0),
    .pwm_len_sel(2'h0), .ch_cmp_wr, .ch_cmp_wdata, .ch_cmp_val,
    .ch_flag, .ch_flag_clr, .ch_route_en, .channel_pin_in,
    .channel_pin_out, .channel_pin_oe
  );

  // ------------------------------------------------------------
  // Clock, count model, timeout and checks
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Expected count, valid only while the system clock source is selected
  always @(posedge core_clk) begin
    if (sys_rst)
      exp_q <= 16'h0000;
    else if (timebase_select == CAT_TB_SYS && !(cpu_idle && idle_halt_select))
      exp_q <= exp_q + 16'h0001;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 75000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic check_val(input string name, input logic [15:0] exp,
                           input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  function automatic logic [15:0] live();
    return {count_high_byte, count_low_byte};
  endfunction : live

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_read();
    logic [7:0] lo, hi;
    for (int i = 0; i < 400 && exp_q !== 16'h00FC; i++) tick(1);
    check_val("count", exp_q, live());
    rd_low_stb = 1'b1;
    lo = exp_q[7:0];
    hi = exp_q[15:8];
    tick(1);
    rd_low_stb = 1'b0;
    check_val("low read", {8'h00, lo}, {8'h00, rd_data});
    tick(8);
    rd_high_stb = 1'b1;
    tick(1);
    rd_high_stb = 1'b0;
    check_val("snapshot", {8'h00, hi}, {8'h00, rd_data});
    check_val("count after reads", exp_q, live());
    rd_low_stb = 1'b1;
    lo = exp_q[7:0];
    hi = exp_q[15:8];
    tick(1);
    rd_low_stb = 1'b0;
    rd_high_stb = 1'b1;
    check_val("low b2b", {8'h00, lo}, {8'h00, rd_data});
    tick(1);
    rd_high_stb = 1'b0;
    check_val("high b2b", {8'h00, hi}, {8'h00, rd_data});
    rd_low_stb = 1'b1;
    hi = exp_q[15:8];
    tick(1);
    rd_low_stb = 1'b0;
    tick(2);
    rd_high_stb = 1'b1;
    tick(1);
    rd_high_stb = 1'b0;
    check_val("high gap", {8'h00, hi}, {8'h00, rd_data});
  endtask : t_read

  task automatic t_idle();
    cpu_idle = 1'b1;
    tick(20);
    check_val("idle count", exp_q, live());
    idle_halt_select = 1'b1;
    tick(20);
    check_val("halted count", exp_q, live());
    cpu_idle = 1'b0;
    idle_halt_select = 1'b0;
  endtask : t_idle

  task automatic t_wrap();
    for (int i = 0; i < 70000 && exp_q !== 16'hFFFF; i++) tick(1);
    check_val("flag at max", 16'h0000, {15'h0, wrap_flag});
    tick(1);
    check_val("wrapped count", 16'h0000, live());
    check_val("flag set", 16'h0001, {15'h0, wrap_flag});
    check_val("irq masked", 16'h0000, {15'h0, irq});
    wrap_irq_enable = 1'b1;
    tick(1);
    check_val("irq raised", 16'h0001, {15'h0, irq});
    tick(30);
    check_val("flag sticky", 16'h0001, {15'h0, wrap_flag});
    wrap_flag_clr = 1'b1;
    tick(1);
    wrap_flag_clr = 1'b0;
    check_val("flag cleared", 16'h0000, {15'h0, wrap_flag});
    check_val("irq dropped", 16'h0000, {15'h0, irq});
  endtask : t_wrap

  // Each event is 8 cycles: pin edges at clk/8, inside the clk/4 limit
  task automatic t_src(input logic [2:0] sel, input int n,
                       input logic [15:0] d);
    logic [15:0] c0;
    timebase_select = sel;
    tick(12);
    c0 = live();
    for (int i = 0; i < n; i++) begin
      case (sel)
        CAT_TB_T0OVF: timer0_ovf = 1'b1;
        CAT_TB_EXTIN: external_count_input = 1'b1;
        CAT_TB_XOSC:  ext_osc = 1'b1;
        CAT_TB_LFOSC: lf_osc = 1'b1;
        default: ;
      endcase
      tick(1);
      timer0_ovf = 1'b0;
      tick(3);
      external_count_input = 1'b0;
      ext_osc = 1'b0;
      lf_osc = 1'b0;
      tick(4);
    end
    tick(12);
    check_val("count delta", d, live() - c0);
  endtask : t_src

  task automatic t_capture();
    logic [15:0] c0;
    timebase_select = CAT_TB_RSVD;
    ch_mode = 9'h000;
    ch_cap_pos = 3'h1;
    ch_cap_neg = 3'h2;
    tick(8);
    c0 = live();
    channel_pin_in = 3'h3;
    tick(8);
    check_val("flags rise", 16'h0001, {13'h0, ch_flag});
    check_val("capture 0", c0, ch_cmp_val[15:0]);
    channel_pin_in = 3'h0;
    tick(8);
    check_val("flags fall", 16'h0003, {13'h0, ch_flag});
    check_val("capture 1", c0, ch_cmp_val[31:16]);
    ch_flag_clr = 3'h3;
    tick(1);
    ch_flag_clr = 3'h0;
    check_val("flags clear", 16'h0000, {13'h0, ch_flag});
    ch_cmp_wdata[47:32] = 16'hA5C3;
    ch_cmp_wr = 3'h4;
    tick(1);
    ch_cmp_wr = 3'h0;
    check_val("compare 2", 16'hA5C3, ch_cmp_val[47:32]);
  endtask : t_capture

  // Timer on ch0, fast output on ch1, 8-bit edge PWM at half duty on ch2
  task automatic t_output();
    logic [15:0] c;
    logic [15:0] hi_n;
    c = live();
    hi_n = 16'h0000;
    timebase_select = CAT_TB_SYS;
    ch_mode = 9'h199;
    ch_cmp_en = 3'h7;
    ch_cmp_wdata = {16'h0080, c + 16'h0014, c + 16'h0014};
    ch_cmp_wr = 3'h7;
    tick(1);
    ch_cmp_wr = 3'h0;
    check_val("oe unrouted", 16'h0000, {13'h0, channel_pin_oe});
    ch_route_en = 3'h7;
    tick(10);
    check_val("oe routed", 16'h0006, {13'h0, channel_pin_oe});
    check_val("flags early", 16'h0000, {13'h0, ch_flag});
    tick(10);
    check_val("flags match", 16'h0003, {13'h0, ch_flag});
    check_val("toggle", 16'h0001, {15'h0, channel_pin_out[1]});
    for (int i = 0; i < 256; i++) begin
      tick(1);
      hi_n = hi_n + {15'h0, channel_pin_out[2]};
    end
    check_val("pwm duty", 16'h0080, hi_n);
    ch_cmp_en = 3'h0;
    tick(2);
    check_val("cmp off", 16'h0002, {13'h0, channel_pin_out});
  endtask : t_output

  initial begin
    {timer0_ovf, external_count_input, ext_osc, lf_osc} = 4'h0;
    {cpu_idle, idle_halt_select, rd_low_stb, rd_high_stb} = 4'h0;
    {wrap_flag_clr, wrap_irq_enable} = 2'h0;
    {ch_cap_pos, ch_cap_neg, ch_cmp_wr, ch_flag_clr} = 12'h000;
    channel_pin_in = 3'h0;
    {ch_cmp_en, ch_route_en} = 6'h00;
    ch_cmp_wdata = 48'h0;
    ch_mode = 9'h1FF;
    timebase_select = CAT_TB_SYS;
    sys_rst = 1'b1;
    n_fail = 0;
    n_compared = 0;
    tick(8);
    check_val("reset count", 16'h0000, live());
    check_val("reset read", 16'h0000, {8'h00, rd_data});
    check_val("reset flag", 16'h0000, {14'h0, wrap_flag, irq});
    sys_rst = 1'b0;
    t_read();
    t_idle();
    t_wrap();
    t_src(CAT_TB_DIV12, 15, 16'h000B);
    t_src(CAT_TB_DIV4, 15, 16'h0021);
    t_src(CAT_TB_T0OVF, 5, 16'h0005);
    t_src(CAT_TB_EXTIN, 6, 16'h0006);
    t_src(CAT_TB_SYS, 15, 16'h0084);
    t_src(CAT_TB_XOSC, 16, 16'h0002);
    t_src(CAT_TB_LFOSC, 16, 16'h0002);
    t_src(CAT_TB_RSVD, 15, 16'h0000);
    t_capture();
    t_output();
    complete_run();
  end
endmodule : cat_timebase_tb
`default_nettype wire
